// ### common/dic_defs.svh
//
// Contract
// - Each input has an invert setting, default off; on, output is complement.
// - A level change reaches the output only after its full debounce interval.
// - Debounce choice per input: none, 20 ms, 50 ms, 100 ms; none default.
// - Pulses shorter than the selected interval never change the output.
// - Four inputs, each with its own independent invert and debounce setting.
`ifndef DIC_DEFS_SVH
`define DIC_DEFS_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define DIC_NUM_IN 4
`define DIC_CNT_W 20
`define DIC_ADDR_W 8
`define DIC_DATA_W 32

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DIC_CLK_KHZ 10000
`define DIC_DEB20_MS 20
`define DIC_DEB50_MS 50
`define DIC_DEB100_MS 100

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define DIC_OFS_CFG 8'h00
`define DIC_OFS_STAT 8'h04
`define DIC_OFS_CHG 8'h08
`define DIC_CFG_STRIDE 4
`define DIC_CFG_INV_POS 0
`define DIC_CFG_SEL_POS 1
`define DIC_CFG_W 16
`define DIC_CFG_RST 16'h0000
`define DIC_STAT_RAW_POS 4

`endif

// ### common/dic_pkg.sv
package dic_pkg;

  typedef enum logic [1:0] {
    DIC_DEB_NONE,
    DIC_DEB_20,
    DIC_DEB_50,
    DIC_DEB_100
  } dic_deb_type;

  typedef enum logic {
    DIC_CH_STABLE,
    DIC_CH_PENDING
  } dic_phase_type;

  typedef struct packed {
    dic_phase_type phase;
    logic [19:0] count;
    logic accepted;
    logic cond;
  } dic_chan_type;

endpackage

// ### common/dic_chan_if.sv
`timescale 1ns/1ns
`include "dic_defs.svh"

interface dic_chan_if;
  logic rawIn;
  logic invert;
  dic_pkg::dic_deb_type debSel;
  logic [`DIC_CNT_W-1:0] limit;
  logic condOut;

  modport chan (
    input rawIn,
    input invert,
    input debSel,
    input limit,
    output condOut
  );

  modport ctrl (
    output rawIn,
    output invert,
    output debSel,
    output limit,
    input condOut
  );
endinterface

// ### src/dic_channel.sv
`timescale 1ns/1ns
`include "dic_defs.svh"

module dic_channel (
  input wire logic clk,
  input wire logic nrst,
  dic_chan_if.chan bus
);

  dic_pkg::dic_chan_type st_ff;
  dic_pkg::dic_chan_type nxt_st;

  // ----------------------------------------------------------------------
  // Debounce filter
  // ----------------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    if (bus.debSel == dic_pkg::DIC_DEB_NONE)
    begin
      nxt_st.accepted = bus.rawIn;
      nxt_st.count = '0;
      nxt_st.phase = dic_pkg::DIC_CH_STABLE;
    end
    else if (bus.rawIn == st_ff.accepted)
    begin
      // A bounce back drops the pending change and its elapsed time.
      nxt_st.count = '0;
      nxt_st.phase = dic_pkg::DIC_CH_STABLE;
    end
    else
    begin
      case (st_ff.phase)
        dic_pkg::DIC_CH_STABLE,
        dic_pkg::DIC_CH_PENDING:
        begin
          if (st_ff.count >= bus.limit - 1'b1)
          begin
            nxt_st.accepted = bus.rawIn;
            nxt_st.count = '0;
            nxt_st.phase = dic_pkg::DIC_CH_STABLE;
          end
          else
          begin
            nxt_st.count = st_ff.count + 1'b1;
            nxt_st.phase = dic_pkg::DIC_CH_PENDING;
          end
        end
        default:
        begin
          nxt_st.count = '0;
          nxt_st.phase = dic_pkg::DIC_CH_STABLE;
        end
      endcase
    end
    // Inversion sits after the filter, so changing it acts on the next clock without waiting out the debounce.
    nxt_st.cond = nxt_st.accepted ^ bus.invert;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign bus.condOut = st_ff.cond;

endmodule // dic_channel

// ### src/dic_top.sv
`timescale 1ns/1ns
`include "dic_defs.svh"

module dic_top #(
  parameter int DEB20_CYC = `DIC_DEB20_MS * `DIC_CLK_KHZ,
  parameter int DEB50_CYC = `DIC_DEB50_MS * `DIC_CLK_KHZ,
  parameter int DEB100_CYC = `DIC_DEB100_MS * `DIC_CLK_KHZ
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [`DIC_NUM_IN-1:0] rawIn,
  output logic [`DIC_NUM_IN-1:0] condOut,
  input wire logic [`DIC_ADDR_W-1:0] addr,
  input wire logic [`DIC_DATA_W-1:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [`DIC_DATA_W-1:0] rdData
);

  localparam logic [`DIC_CNT_W-1:0] LIM20 = DEB20_CYC[`DIC_CNT_W-1:0];
  localparam logic [`DIC_CNT_W-1:0] LIM50 = DEB50_CYC[`DIC_CNT_W-1:0];
  localparam logic [`DIC_CNT_W-1:0] LIM100 = DEB100_CYC[`DIC_CNT_W-1:0];

  typedef struct packed {
    logic [`DIC_CFG_W-1:0] cfg;
    logic [`DIC_NUM_IN-1:0] chg;
    logic [`DIC_NUM_IN-1:0] prev;
    logic [`DIC_DATA_W-1:0] rd;
  } dic_regs_type;

  dic_regs_type st_ff;
  dic_regs_type nxt_st;
  logic [`DIC_NUM_IN-1:0] condW;

  // ----------------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < `DIC_NUM_IN; i++)
  begin : g_ch
    localparam int B = i * `DIC_CFG_STRIDE;
    dic_chan_if u_if ();
    logic [1:0] selBits;

    assign selBits = st_ff.cfg[B + `DIC_CFG_SEL_POS +: 2];
    assign u_if.rawIn = rawIn[i];
    assign u_if.invert = st_ff.cfg[B + `DIC_CFG_INV_POS];
    assign u_if.debSel = dic_pkg::dic_deb_type'(selBits);
    always_comb
    begin
      case (u_if.debSel)
        dic_pkg::DIC_DEB_20: u_if.limit = LIM20;
        dic_pkg::DIC_DEB_50: u_if.limit = LIM50;
        dic_pkg::DIC_DEB_100: u_if.limit = LIM100;
        default: u_if.limit = '0;
      endcase
    end
    assign condW[i] = u_if.condOut;

    dic_channel u_ch (
      .clk(clk),
      .nrst(nrst),
      .bus(u_if.chan)
    );
  end

  // ----------------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rd = '0;
    nxt_st.prev = condW;
    if (wrEn && addr == `DIC_OFS_CFG)
      nxt_st.cfg = wrData[`DIC_CFG_W-1:0];
    if (wrEn && addr == `DIC_OFS_CHG)
      nxt_st.chg = st_ff.chg & ~wrData[`DIC_NUM_IN-1:0];
    // A fresh change wins over a clear in the same cycle.
    nxt_st.chg = nxt_st.chg | (condW ^ st_ff.prev);
    if (rdEn)
    begin
      case (addr)
        `DIC_OFS_CFG: nxt_st.rd[`DIC_CFG_W-1:0] = st_ff.cfg;
        `DIC_OFS_STAT:
        begin
          nxt_st.rd[`DIC_NUM_IN-1:0] = condW;
          nxt_st.rd[`DIC_STAT_RAW_POS +: `DIC_NUM_IN] = rawIn;
        end
        `DIC_OFS_CHG: nxt_st.rd[`DIC_NUM_IN-1:0] = st_ff.chg;
        default: nxt_st.rd = '0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_ff.cfg <= `DIC_CFG_RST;
      st_ff.chg <= '0;
      st_ff.prev <= '0;
      st_ff.rd <= '0;
    end
    else
      st_ff <= nxt_st;
  end

  // Both come from flip-flops: rd here, cond inside each channel.
  assign rdData = st_ff.rd;
  assign condOut = condW;

endmodule // dic_top

// ### verification/dic_top_checker.sv
`timescale 1ns/1ns
`include "dic_defs.svh"
module dic_top_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [`DIC_NUM_IN-1:0] rawIn,
  input wire logic [`DIC_NUM_IN-1:0] condOut,
  input wire logic [`DIC_ADDR_W-1:0] addr,
  input wire logic [`DIC_DATA_W-1:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [`DIC_DATA_W-1:0] rdData
);
  // Shadow of the settings word, because the ports show it only on a read.
  logic [15:0] cfg_ff;
  always_ff @(posedge clk)
  begin
    if (!nrst)
      cfg_ff <= 16'h0000;
    else if (wrEn && addr == `DIC_OFS_CFG)
      cfg_ff <= wrData[15:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  plain_one_a: assert property (
    cfg_ff[2:1] == 2'h0 && $past(cfg_ff[2:1]) == 2'h0
    |=> condOut[0] == ($past(rawIn[0]) ^ $past(cfg_ff[0])))
    else $error("plain path one");
  plain_two_a: assert property (
    cfg_ff[6:5] == 2'h0 && $past(cfg_ff[6:5]) == 2'h0
    |=> condOut[1] == ($past(rawIn[1]) ^ $past(cfg_ff[4])))
    else $error("plain path two");
  early_rise_a: assert property (
    $rose(rawIn[0]) && cfg_ff[2:0] == 3'h2 && !condOut[0]
    |=> !condOut[0] [*4])
    else $error("early rise");
  late_rise_a: assert property (
    $rose(rawIn[0]) && cfg_ff[2:0] == 3'h2 ##0 rawIn[0] [*5]
    |=> condOut[0])
    else $error("late rise");
  idle_read_a: assert property (
    !$past(rdEn) |-> rdData == 32'h0)
    else $error("idle read data");
  hold_level_a: assert property (
    cfg_ff[2:0] == 3'h2 && $stable(cfg_ff) && $stable(rawIn[0])
    && rawIn[0] == condOut[0] |=> $stable(condOut[0]))
    else $error("level moved");
endmodule // dic_top_checker

bind dic_top dic_top_checker i_dic_top_checker (.clk, .nrst, .rawIn,
  .condOut, .addr, .wrData, .wrEn, .rdEn, .rdData);

// ### verification/dic_field.sv
`timescale 1ns/1ns
module dic_field (
  input wire logic clk,
  output logic [3:0] rawIn
);
  initial rawIn = 4'h0;
  task automatic drive(input logic [3:0] v);
    @(posedge clk);
    rawIn <= v;
  endtask
endmodule // dic_field

// ### verification/dic_top_tb.sv
`timescale 1ns/1ns
module dic_top_tb;
  logic clk, nrst, wrEn, rdEn;
  logic [7:0] addr;
  logic [31:0] wrData, rdData;
  logic [3:0] rawIn, condOut, m;
  int miscompares = 0;
  int num_checks = 0;
  dic_field i_dic_field (.clk(clk), .rawIn(rawIn));
  // Short counts keep the run brief: 5, 10 and 20 cycles.
  dic_top #(.DEB20_CYC(5), .DEB50_CYC(10), .DEB100_CYC(20)) i_dic_top (
    .clk(clk), .nrst(nrst), .rawIn(rawIn), .condOut(condOut), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData));
  // ------------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("Error %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'h1;
    @(posedge clk);
    wrEn <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'h1;
    @(posedge clk);
    rdEn <= 1'h0;
    #1 chk(rdData, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic finish_test();
    if (miscompares == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    #200000;
    miscompares++;
    finish_test();
  end
  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial
  begin
    nrst = 1'h0;
    wrEn = 1'h0;
    rdEn = 1'h0;
    addr = 8'h00;
    wrData = 32'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    rd(8'h00, 32'h0);
    rd(8'h0C, 32'h0);
    i_dic_field.drive(4'h5);
    rd(8'h04, 32'h55);
    rd(8'hF4, 32'h0);
    wr(8'h0B, 32'hFFFF);
    wr(8'h00, 32'hFFFF1111);
    rd(8'h04, 32'h5A);
    rd(8'h00, 32'h1111);
    wr(8'h00, 32'h0642);
    i_dic_field.drive(4'hA);
    for (int k = 1; k < 22; k++)
    begin
      tick(1);
      m = {1'h1, k >= 20, k >= 10, k >= 5};
      chk({28'h0, condOut}, {28'h0, (4'h5 & ~m) | (4'hA & m)});
    end
    i_dic_field.drive(4'hB);
    tick(3);
    i_dic_field.drive(4'hA);
    tick(8);
    chk({28'h0, condOut}, 32'hA);
    i_dic_field.drive(4'hB);
    tick(2);
    i_dic_field.drive(4'hA);
    i_dic_field.drive(4'hB);
    tick(4);
    chk({28'h0, condOut}, 32'hA);
    tick(1);
    chk({28'h0, condOut}, 32'hB);
    rd(8'h08, 32'hF);
    wr(8'h08, 32'hFFFFFFF5);
    rd(8'h08, 32'hA);
    // Input four toggles in the very cycle that the clear lands.
    i_dic_field.drive(4'h3);
    wr(8'h08, 32'hF);
    rd(8'h08, 32'h8);
    @(posedge clk);
    nrst <= 1'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    rd(8'h00, 32'h0);
    chk({28'h0, condOut}, 32'h3);
    rd(8'h08, 32'h3);
    finish_test();
  end
endmodule // dic_top_tb
